// >>> rtl/pcc_regs.svh
// register offsets, field positions and reset values of the clock control block
`ifndef PCC_REGS_SVH
`define PCC_REGS_SVH
`define PCC_CLK_OFF        32'h0080_0010
`define PCC_DBT_OFF        32'h8000_1030
`define PCC_CLK_RESET      16'h2126
`define PCC_CLK_MASK       16'hFFFF
`define PCC_COMMS_EN_BIT   15
`define PCC_DISP_EN_BIT    14
`define PCC_DISP_HI        13
`define PCC_DISP_LO        8
`define PCC_MUTE_BIT       7
`define PCC_IMM_BIT        6
`define PCC_SYS_HI         5
`define PCC_SYS_LO         0
`define PCC_SYS_RESET      6'h26
`define PCC_DBT_FORCE_BIT  8
`define PCC_DBT_NOREQ_BIT  4
`define PCC_DBT_TEST_BIT   3
`define PCC_DBT_SEL_HI     2
`define PCC_DBT_SEL_LO     0
`define PCC_DBT_CNT_BIT    5
`define PCC_DBT_PRE_HI     3
`define PCC_RESP_OKAY      2'h0
`define PCC_RESP_SLVERR    2'h2
`endif

// >>> rtl/pcc_pkg.sv
// types of the clock control block
package pcc_pkg;
  typedef enum logic [1:0] {
    PCC_IDLE = 2'b01,
    PCC_RESP = 2'b10
  } pcc_bus_st_t;
  typedef struct packed {
    pcc_bus_st_t wst;
    pcc_bus_st_t rst;
    logic        aw_got;
    logic        w_got;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [15:0] clk_ctl;
    logic [5:0]  sys_code;
    logic        por_mute_done;
    logic        sys_mute;
    logic        sys_kick;
    logic        comms_gate;
    logic        disp_gate;
    logic        clk_inhibit;
    logic [8:0]  dbt;
    logic        lk_prev;
  } pcc_state_t;
endpackage

// >>> rtl/pcc_clock_control.sv
// clock control and debounce test registers behind an axi4-lite slave
// Summary of operation
// - clock control register resets to 0x2126.
// - bits 15/14 enable comms/display pll, output gated until lock.
// - bits 5:0 select system pll code, default 0x26.
// - bit 7 mutes system pll only after power-on reset.
// - bit 6 low: code buffered, applied when system lock drops.
// - bit 6 high: new code drops lock, inhibits core and bus clocks.
// - test bit 8 forces core and bus clocks active.
// - test bit 4 suppresses the unit's bus request.
// - test bit 3 forces local test mode, else pin value.
// - test bits 2:0 select the observed debounce counter.
// - test read returns counter bit high and prescaler bits low.
// - counters run at 4 kHz tick, test register only observes.
`include "pcc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pcc_clock_control
  import pcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sys_lock_detect,
  input  wire logic        comms_lock_detect,
  input  wire logic        disp_lock_detect,
  input  wire logic        test_mode_pin_n,
  input  wire logic [7:0]  debounce_counter_bits,
  input  wire logic [2:0]  prescaler_bits,
  input  wire logic        pmu_bus_request,
  output logic             comms_pll_enable,
  output logic             disp_pll_enable,
  output logic             comms_clk_gate_open,
  output logic             disp_clk_gate_open,
  output logic [5:0]       disp_pll_code,
  output logic [5:0]       sys_pll_code,
  output logic             sys_pll_load,
  output logic             sys_pll_mute,
  output logic             core_clock_inhibit,
  output logic             core_clock_force,
  output logic             pmu_bus_request_out,
  output logic             test_mode_n,
  output logic [2:0]       debounce_select
);
  pcc_state_t s_q;
  pcc_state_t s_d;
  // two-flop synchronisers for asynchronous inputs
  logic [15:0] sy1_q;
  logic [15:0] sy2_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // test pin idles high, so its stages reset high to avoid a false test entry
      sy1_q <= 16'h0010;
      sy2_q <= 16'h0010;
    end else begin
      sy1_q <= {debounce_counter_bits, prescaler_bits, test_mode_pin_n,
                disp_lock_detect, comms_lock_detect, sys_lock_detect, pmu_bus_request};
      sy2_q <= sy1_q;
    end
  end
  logic [7:0] cnt_s;
  logic [2:0] pre_s;
  logic       tpin_s;
  logic       dlk_s;
  logic       clk_s;
  logic       slk_s;
  logic       breq_s;
  assign {cnt_s, pre_s, tpin_s, dlk_s, clk_s, slk_s, breq_s} = sy2_q;

  logic        wr_fire;
  logic        wr_clk;
  logic        wr_dbt;
  logic [15:0] wmask;
  logic [15:0] new_clk;
  logic        rd_clk;
  logic        rd_dbt;
  logic [5:0]  code_wr;
  assign wmask = {{8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};
  assign wr_fire = s_q.wst == PCC_IDLE && s_q.aw_got && s_q.w_got;
  assign wr_clk = wr_fire && s_q.awaddr == `PCC_CLK_OFF;
  assign wr_dbt = wr_fire && s_q.awaddr == `PCC_DBT_OFF;
  assign new_clk = (s_q.clk_ctl & ~wmask) | (s_q.wdata[15:0] & wmask & `PCC_CLK_MASK);
  assign code_wr = new_clk[`PCC_SYS_HI:`PCC_SYS_LO];
  assign rd_clk = s_axi_araddr == `PCC_CLK_OFF;
  assign rd_dbt = s_axi_araddr == `PCC_DBT_OFF;

  //==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.sys_kick = 1'b0;
    s_d.lk_prev = slk_s;
    if (s_axi_awvalid && !s_q.aw_got && s_q.wst == PCC_IDLE) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = {s_axi_awaddr[31:2], 2'b00};
    end
    if (s_axi_wvalid && !s_q.w_got && s_q.wst == PCC_IDLE) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (wr_fire) begin
      s_d.wst = PCC_RESP;
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bresp = (wr_clk || wr_dbt) ? `PCC_RESP_OKAY : `PCC_RESP_SLVERR;
    end else if (s_q.wst == PCC_RESP && s_axi_bready) begin
      s_d.wst = PCC_IDLE;
    end
    if (wr_clk) begin
      s_d.clk_ctl = new_clk;
      if (new_clk[`PCC_IMM_BIT] && code_wr != s_q.sys_code) begin
        s_d.sys_code = code_wr;
        s_d.sys_kick = 1'b1;
        s_d.clk_inhibit = 1'b1;
      end
    end
    if (wr_dbt && s_q.wstrb[0]) begin
      s_d.dbt[7:0] = {3'h0, s_q.wdata[`PCC_DBT_NOREQ_BIT:`PCC_DBT_SEL_LO]};
    end
    if (wr_dbt && s_q.wstrb[1]) begin
      s_d.dbt[`PCC_DBT_FORCE_BIT] = s_q.wdata[`PCC_DBT_FORCE_BIT];
    end
    // buffered code moves on the falling edge of system lock
    if (s_q.lk_prev && !slk_s) begin
      if (!s_q.clk_ctl[`PCC_IMM_BIT]) begin
        s_d.sys_code = s_q.clk_ctl[`PCC_SYS_HI:`PCC_SYS_LO];
        s_d.sys_kick = 1'b1;
      end
    end
    // a new immediate code wins over a stale lock in the same cycle
    if (slk_s && !s_q.sys_kick && !s_d.sys_kick) begin
      s_d.clk_inhibit = 1'b0;
      if (!s_q.por_mute_done) begin
        s_d.por_mute_done = 1'b1;
      end
    end
    // mute only until first lock after power-on reset
    s_d.sys_mute = s_q.clk_ctl[`PCC_MUTE_BIT] && !s_q.por_mute_done;
    s_d.comms_gate = s_q.clk_ctl[`PCC_COMMS_EN_BIT] && clk_s;
    s_d.disp_gate = s_q.clk_ctl[`PCC_DISP_EN_BIT] && dlk_s;
    if (s_axi_arvalid && s_q.rst == PCC_IDLE) begin
      s_d.rst = PCC_RESP;
      s_d.rresp = `PCC_RESP_OKAY;
      if (rd_clk) begin
        s_d.rdata = {16'h0000, s_q.clk_ctl};
      end else if (rd_dbt) begin
        s_d.rdata = {26'h0, cnt_s[s_q.dbt[`PCC_DBT_SEL_HI:`PCC_DBT_SEL_LO]],
                     2'b00, pre_s};
      end else begin
        s_d.rdata = 32'h0000_0000;
        s_d.rresp = `PCC_RESP_SLVERR;
      end
    end else if (s_q.rst == PCC_RESP && s_axi_rready) begin
      s_d.rst = PCC_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.wst <= PCC_IDLE;
      s_q.rst <= PCC_IDLE;
      s_q.clk_ctl <= `PCC_CLK_RESET;
      s_q.sys_code <= `PCC_SYS_RESET;
      s_q.sys_mute <= 1'b1;
      s_q.clk_inhibit <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  //==========================================================
  // registered outputs
  logic [5:0] disp_q;
  logic       breq_q;
  logic       tmode_q;
  logic       force_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      disp_q <= 6'h21;
      breq_q <= 1'b0;
      tmode_q <= 1'b1;
      force_q <= 1'b0;
    end else begin
      disp_q <= s_q.clk_ctl[`PCC_DISP_HI:`PCC_DISP_LO];
      breq_q <= breq_s && !s_q.dbt[`PCC_DBT_NOREQ_BIT];
      tmode_q <= s_q.dbt[`PCC_DBT_TEST_BIT] ? 1'b0 : tpin_s;
      force_q <= s_q.dbt[`PCC_DBT_FORCE_BIT];
    end
  end
  assign s_axi_awready = s_q.wst == PCC_IDLE && !s_q.aw_got;
  assign s_axi_wready = s_q.wst == PCC_IDLE && !s_q.w_got;
  assign s_axi_bvalid = s_q.wst == PCC_RESP;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.rst == PCC_IDLE;
  assign s_axi_rvalid = s_q.rst == PCC_RESP;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign comms_pll_enable = s_q.clk_ctl[`PCC_COMMS_EN_BIT];
  assign disp_pll_enable = s_q.clk_ctl[`PCC_DISP_EN_BIT];
  assign comms_clk_gate_open = s_q.comms_gate;
  assign disp_clk_gate_open = s_q.disp_gate;
  assign disp_pll_code = disp_q;
  assign sys_pll_code = s_q.sys_code;
  assign sys_pll_load = s_q.sys_kick;
  assign sys_pll_mute = s_q.sys_mute;
  assign core_clock_inhibit = s_q.clk_inhibit && !force_q;
  assign core_clock_force = force_q;
  assign pmu_bus_request_out = breq_q;
  assign test_mode_n = tmode_q;
  assign debounce_select = s_q.dbt[`PCC_DBT_SEL_HI:`PCC_DBT_SEL_LO];

  //==========================================================
  // checks
  immediate_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_clk && new_clk[`PCC_IMM_BIT] && code_wr != s_q.sys_code
    |=> sys_pll_code == $past(code_wr) && sys_pll_load && core_clock_inhibit || force_q)
    else $error("immediate code not applied");
  buffered_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_clk && !new_clk[`PCC_IMM_BIT] && !(s_q.lk_prev && !slk_s)
    |=> sys_pll_code == $past(sys_pll_code))
    else $error("buffered code applied early");
  buffered_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.lk_prev && !slk_s && !s_q.clk_ctl[`PCC_IMM_BIT] |=> sys_pll_load)
    else $error("buffered code not loaded");
  mute_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.por_mute_done |=> !sys_pll_mute)
    else $error("mute after power-on");
  gate_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
    comms_clk_gate_open |-> comms_pll_enable || $past(comms_pll_enable))
    else $error("comms gate open while off");
  bus_req_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.dbt[`PCC_DBT_NOREQ_BIT] && $past(s_q.dbt[`PCC_DBT_NOREQ_BIT]) |-> !pmu_bus_request_out)
    else $error("bus request not suppressed");
  test_force_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(s_q.dbt[`PCC_DBT_TEST_BIT]) |-> !test_mode_n)
    else $error("local test mode not forced");
  clk_force_a: assert property (@(posedge clk) disable iff (!rst_n)
    core_clock_force |-> !core_clock_inhibit)
    else $error("forced clock inhibited");
  rsvd_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("reserved bits nonzero");
endmodule
`default_nettype wire

// >>> verification/pcc_testbench.sv
// self-checking testbench of the clock control and debounce test registers
`include "pcc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pcc_pkg::*;
;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
    logic [1:0]  resp;
  } pcc_row_t;
  logic        clk, rst_n;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        sys_lk, comms_lk, disp_lk, pin_n, req;
  logic        comms_en, disp_en, comms_gt, disp_gt, load, mute, inhibit, force_o, req_o, tmode_n;
  logic [5:0]  disp_code, sys_code;
  logic [2:0]  dsel;
  logic [31:0] rd_v;
  logic [1:0]  rs_v;
  int          checks, n_fail;
  pcc_row_t    rows [6];
  pcc_clock_control i_dut (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sys_lock_detect(sys_lk), .comms_lock_detect(comms_lk), .disp_lock_detect(disp_lk),
    .test_mode_pin_n(pin_n), .debounce_counter_bits(8'h12), .prescaler_bits(3'h5),
    .pmu_bus_request(req), .comms_pll_enable(comms_en), .disp_pll_enable(disp_en),
    .comms_clk_gate_open(comms_gt), .disp_clk_gate_open(disp_gt), .disp_pll_code(disp_code),
    .sys_pll_code(sys_code), .sys_pll_load(load), .sys_pll_mute(mute),
    .core_clock_inhibit(inhibit), .core_clock_force(force_o), .pmu_bus_request_out(req_o),
    .test_mode_n(tmode_n), .debounce_select(dsel));
  always #2 clk = ~clk;
  // ==========================================
  // bus cycles and comparison
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // handshakes are judged on settled values at the falling edge before the taking edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic aw_hs;
    logic w_hs;
    logic b_hs;
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    do begin
      @(negedge clk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      rs_v = bresp;
      @(posedge clk);
      if (aw_hs) awvalid <= 1'h0;
      if (w_hs) wvalid <= 1'h0;
    end while (b_hs !== 1'h1);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [31:0] a);
    logic ar_hs;
    logic r_hs;
    @(posedge clk);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    do begin
      @(negedge clk);
      ar_hs = arvalid && arready;
      r_hs = rvalid;
      rd_v = rdata;
      rs_v = rresp;
      @(posedge clk);
      if (ar_hs) arvalid <= 1'h0;
    end while (r_hs !== 1'h1);
    rready <= 1'h0;
  endtask
  task automatic end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================
  // watchdog
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
  // ==========================================
  // main sequence
  initial begin
    clk = 1'h0; rst_n = 1'h0; awaddr = 32'h0; wdata = 32'h0; araddr = 32'h0; wstrb = 4'h0;
    awvalid = 1'h0; wvalid = 1'h0; bready = 1'h0; arvalid = 1'h0; rready = 1'h0;
    sys_lk = 1'h0; comms_lk = 1'h0; disp_lk = 1'h0; pin_n = 1'h1; req = 1'h1;
    checks = 0; n_fail = 0;
    rows[0] = '{`PCC_CLK_OFF, 32'hFFFF_E126, 32'h0000_E126, `PCC_RESP_OKAY};
    rows[1] = '{`PCC_DBT_OFF, 32'hFFFF_FFE0, 32'h0000_0005, `PCC_RESP_OKAY};
    rows[2] = '{`PCC_DBT_OFF, 32'hFFFF_FFE1, 32'h0000_0025, `PCC_RESP_OKAY};
    rows[3] = '{`PCC_DBT_OFF, 32'hFFFF_FFE3, 32'h0000_0005, `PCC_RESP_OKAY};
    rows[4] = '{`PCC_DBT_OFF, 32'hFFFF_FFE4, 32'h0000_0025, `PCC_RESP_OKAY};
    rows[5] = '{32'h0080_0014, 32'h0000_FFFF, 32'h0000_0000, `PCC_RESP_SLVERR};
    cyc(2);
    rst_n <= 1'h1;
    chk("sys_code_rst", 32'h26, sys_code);
    chk("inhibit_rst", 32'h1, inhibit);
    chk("tmode_rst", 32'h1, tmode_n);
    rd(`PCC_CLK_OFF);
    chk("clk_ctl_rst", 32'h0000_2126, rd_v);
    chk("disp_code_rst", 32'h21, disp_code);
    for (int i = 0; i < 6; i++) begin
      wr(rows[i].addr, rows[i].wdata);
      chk("bresp", rows[i].resp, rs_v);
      rd(rows[i].addr);
      chk("rdata", rows[i].rexp, rd_v);
      chk("rresp", rows[i].resp, rs_v);
      cyc(2);
      if (rows[i].addr == `PCC_DBT_OFF) chk("dsel", rows[i].wdata[2:0], dsel);
    end
    chk("force_on", 32'h1, force_o);
    chk("inhibit_forced", 32'h0, inhibit);
    rd(`PCC_CLK_OFF);
    chk("clk_ctl_kept", 32'h0000_E126, rd_v);
    // test source, bus request and force off
    pin_n <= 1'h0;
    wr(`PCC_DBT_OFF, 32'h0000_0000);
    cyc(4);
    chk("tmode_pin", 32'h0, tmode_n);
    chk("req_pass", 32'h1, req_o);
    chk("force_off", 32'h0, force_o);
    chk("inhibit_back", 32'h1, inhibit);
    pin_n <= 1'h1;
    wr(`PCC_DBT_OFF, 32'h0000_0018);
    cyc(4);
    chk("tmode_local", 32'h0, tmode_n);
    chk("req_blocked", 32'h0, req_o);
    // pll enables, gating and mute
    comms_lk <= 1'h1;
    wr(`PCC_CLK_OFF, 32'h0000_E1A6);
    cyc(4);
    chk("comms_gate", 32'h1, comms_gt);
    chk("disp_gate", 32'h0, disp_gt);
    chk("disp_en", 32'h1, disp_en);
    chk("mute_on", 32'h1, mute);
    wr(`PCC_CLK_OFF, 32'h0000_21A6);
    cyc(2);
    chk("comms_off", 32'h0, comms_en);
    chk("comms_gate_off", 32'h0, comms_gt);
    sys_lk <= 1'h1;
    cyc(4);
    chk("mute_end", 32'h0, mute);
    chk("inhibit_end", 32'h0, inhibit);
    // buffered code waits for the lock to drop
    wr(`PCC_CLK_OFF, 32'h0000_211B);
    cyc(4);
    chk("code_held", 32'h26, sys_code);
    sys_lk <= 1'h0;
    cyc(5);
    chk("code_loaded", 32'h1B, sys_code);
    chk("mute_stays", 32'h0, mute);
    // immediate code change
    wr(`PCC_CLK_OFF, 32'h0000_2165);
    cyc(2);
    chk("code_now", 32'h25, sys_code);
    chk("inhibit_now", 32'h1, inhibit);
    chk("mute_never", 32'h0, mute);
    sys_lk <= 1'h1;
    cyc(5);
    chk("inhibit_lock", 32'h0, inhibit);
    end_of_test();
  end
endmodule
`default_nettype wire
